// ### verilog/ecx_pkg.sv
package ecx_pkg;

    // ----------------------------------------------------------------
    // register addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_DIR_LO = 8'h06;
    localparam logic [7:0] REG_DIR_HI = 8'h07;
    localparam logic [7:0] REG_CONFIG = 8'h0F;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // ----------------------------------------------------------------
    // configuration fields
    // ----------------------------------------------------------------
    localparam int CFG_BLINK_EN = 0;
    localparam int CFG_PHASE_SEL = 1;
    localparam int CFG_GLOBAL = 2;
    localparam int CFG_IRQ_EN = 3;
    localparam int CFG_AUX_P0 = 4;
    localparam int CFG_AUX_P1 = 5;
    localparam int CFG_RSVD = 6;
    localparam int CFG_CHANGE = 7;
    localparam logic [7:0] CFG_RESET = 8'h0C;
    localparam logic [7:0] CFG_WRITE_MASK = 8'h3F;
    localparam logic [15:0] DIR_RESET = 16'hFFFF;

    // ----------------------------------------------------------------
    // sizes and counts
    // ----------------------------------------------------------------
    localparam int PORTS = 16;
    localparam int HALF = 8;
    localparam int NIBBLE = 4;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LAST_TX_BIT = 4'h7;
    localparam logic [1:0] INIT_SNAP_CYCLES = 2'h3;
    // arbitrary default slave address
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h20;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK_ADDR,
        ST_PTR,
        ST_ACK_PTR,
        ST_WDATA,
        ST_ACK_WDATA,
        ST_RDATA,
        ST_MACK
    } ecx_state_t;

endpackage : ecx_pkg

// ### verilog/ecx_config_regs.sv
// Notes on behaviour
// - config register 0x0F, eight documented fields
// - config bit D6 always reads zero
// - blink on: D1 selects phase set
// - D2 low: per-port own intensity, aux always uses master intensity
// - D2 high: outputs use master intensity
// - D3 low: shared pin follows aux levels
// - D3 high: shared pin is low-active interrupt
// - no irq, no blink: D4 drives pin
// - blink phase 0: pin follows D4
// - blink phase 1: pin follows D5
// - D7 reads input change flag
// - direction registers 0x06/0x07, 1 = input
// - direction registers read back written values
// - blink off: phase select ignored
// - flag on input differing from snapshot
// - reset sets all ports as inputs
`timescale 1ns/1ps
module ecx_config_regs
    import ecx_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = ecx_pkg::DEV_ADDR_DEFAULT
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic [15:0] portPin,
    input wire logic snapLow,
    input wire logic snapHigh,
    input wire logic [63:0] portIntensity,
    input wire logic [3:0] masterIntensity,
    output logic [15:0] portOutEn,
    output logic usePhase1,
    output logic [63:0] intensitySel,
    output logic [3:0] auxIntensity,
    output logic sharedIrqAuxPinOut,
    output logic sharedIrqAuxPinOe
);
    import ecx_pkg::*;

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    logic [17:0] syncA_q;
    logic [17:0] syncB_q;
    logic sclPrev_q;
    logic sdaPrev_q;
    logic sclS;
    logic sdaS;
    logic [15:0] pinS;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            syncA_q <= '1;
            syncB_q <= '1;
        end else begin
            syncA_q <= {scl, sdaIn, portPin};
            syncB_q <= syncA_q;
        end
    end

    assign sclS = syncB_q[17];
    assign sdaS = syncB_q[16];
    assign pinS = syncB_q[15:0];

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            sclPrev_q <= 1'b1;
            sdaPrev_q <= 1'b1;
        end else begin
            sclPrev_q <= sclS;
            sdaPrev_q <= sdaS;
        end
    end

    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;
    assign sclRise = sclS && !sclPrev_q;
    assign sclFall = !sclS && sclPrev_q;
    assign startCond = sclS && sclPrev_q && sdaPrev_q && !sdaS;
    assign stopCond = sclS && sclPrev_q && !sdaPrev_q && sdaS;

    // ----------------------------------------------------------------
    // serial slave
    // ----------------------------------------------------------------
    ecx_state_t state_q;
    logic [3:0] bitCnt_q;
    logic [7:0] shift_q;
    logic [7:0] tx_q;
    logic [7:0] ptr_q;
    logic rw_q;
    logic masterNack_q;
    logic [7:0] cfg_q;
    logic [15:0] dir_q;
    logic changeFlag_q;
    logic byteDone;
    logic wrStb;
    logic [7:0] nextPtr;

    assign byteDone = (bitCnt_q == BITS_PER_BYTE);
    // a write lands only once all eight bits are in
    // commit on byte end
    assign wrStb = sclFall && (state_q == ST_WDATA) && byteDone;
    // pointer pairs the two direction bytes, config stays put
    assign nextPtr = (ptr_q == REG_DIR_LO) ? REG_DIR_HI :
                     (ptr_q == REG_DIR_HI) ? REG_DIR_LO : ptr_q;

    function automatic logic [7:0] readMux(input logic [7:0] a);
        readMux = READ_UNMAPPED;
        case (a)
            REG_DIR_LO: readMux = dir_q[HALF-1:0];
            REG_DIR_HI: readMux = dir_q[PORTS-1:HALF];
            REG_CONFIG: begin
                readMux = cfg_q;
                readMux[CFG_CHANGE] = changeFlag_q;
                readMux[CFG_RSVD] = 1'b0;
            end
            default: readMux = READ_UNMAPPED;
        endcase
    endfunction : readMux

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            state_q <= ST_IDLE;
            bitCnt_q <= '0;
            shift_q <= '0;
            rw_q <= 1'b0;
            masterNack_q <= 1'b1;
        end else if (startCond) begin
            state_q <= ST_ADDR;
            bitCnt_q <= '0;
        end else if (stopCond) begin
            state_q <= ST_IDLE;
        end else if (sclRise) begin
            if (state_q inside {ST_ADDR, ST_PTR, ST_WDATA}) begin
                shift_q <= {shift_q[6:0], sdaS};
                bitCnt_q <= bitCnt_q + 4'h1;
            end
            if (state_q == ST_MACK) begin
                masterNack_q <= sdaS;
            end
        end else if (sclFall) begin
            case (state_q)
                ST_ADDR: begin
                    if (byteDone) begin
                        rw_q <= shift_q[0];
                        state_q <= (shift_q[7:1] == DEV_ADDR) ? ST_ACK_ADDR : ST_IDLE;
                    end
                end
                ST_ACK_ADDR: begin
                    state_q <= rw_q ? ST_RDATA : ST_PTR;
                    bitCnt_q <= '0;
                end
                ST_PTR: begin
                    if (byteDone) begin
                        state_q <= ST_ACK_PTR;
                    end
                end
                ST_ACK_PTR, ST_ACK_WDATA: begin
                    state_q <= ST_WDATA;
                    bitCnt_q <= '0;
                end
                ST_WDATA: begin
                    if (byteDone) begin
                        state_q <= ST_ACK_WDATA;
                    end
                end
                ST_RDATA: begin
                    if (bitCnt_q == LAST_TX_BIT) begin
                        state_q <= ST_MACK;
                    end else begin
                        bitCnt_q <= bitCnt_q + 4'h1;
                    end
                end
                ST_MACK: begin
                    state_q <= masterNack_q ? ST_IDLE : ST_RDATA;
                    bitCnt_q <= '0;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            ptr_q <= '0;
        end else if (sclFall && (state_q == ST_PTR) && byteDone) begin
            ptr_q <= shift_q;
        end else if (sclFall && (state_q == ST_ACK_WDATA)) begin
            ptr_q <= nextPtr;
        end else if (sclFall && (state_q == ST_MACK) && !masterNack_q) begin
            ptr_q <= nextPtr;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            tx_q <= '0;
        end else if (sclFall && (state_q == ST_ACK_ADDR) && rw_q) begin
            tx_q <= readMux(ptr_q);
        end else if (sclFall && (state_q == ST_MACK) && !masterNack_q) begin
            tx_q <= readMux(nextPtr);
        end else if (sclFall && (state_q == ST_RDATA)) begin
            tx_q <= {tx_q[6:0], 1'b1};
        end
    end

    // open drain: only ever pull low
    assign sdaOut = 1'b0;
    assign sdaOe = (state_q inside {ST_ACK_ADDR, ST_ACK_PTR, ST_ACK_WDATA})
                   || ((state_q == ST_RDATA) && !tx_q[7]);

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            cfg_q <= CFG_RESET;
        end else if (wrStb && (ptr_q == REG_CONFIG)) begin
            cfg_q <= shift_q & CFG_WRITE_MASK;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            dir_q <= DIR_RESET;
        end else if (wrStb && (ptr_q == REG_DIR_LO)) begin
            dir_q[HALF-1:0] <= shift_q;
        end else if (wrStb && (ptr_q == REG_DIR_HI)) begin
            dir_q[PORTS-1:HALF] <= shift_q;
        end
    end

    // ----------------------------------------------------------------
    // transition detection
    // ----------------------------------------------------------------
    logic [15:0] snap_q;
    logic [1:0] initCnt_q;

    // snapshot held off until synchronisers carry real pin levels
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            snap_q <= '0;
            initCnt_q <= INIT_SNAP_CYCLES;
        end else if (initCnt_q != 2'h0) begin
            snap_q <= pinS;
            initCnt_q <= initCnt_q - 2'h1;
        end else if (wrStb && (ptr_q == REG_CONFIG)) begin
            snap_q <= pinS;
        end else begin
            if (snapLow) begin
                snap_q[HALF-1:0] <= pinS[HALF-1:0];
            end
            if (snapHigh) begin
                snap_q[PORTS-1:HALF] <= pinS[PORTS-1:HALF];
            end
        end
    end

    // flag clears by itself when the input returns
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            changeFlag_q <= 1'b0;
        end else begin
            changeFlag_q <= (initCnt_q == 2'h0) && |((pinS ^ snap_q) & dir_q);
        end
    end

    // ----------------------------------------------------------------
    // output steering
    // ----------------------------------------------------------------
    logic auxLevel;
    logic sharedOe_q;
    logic usePhase1_q;
    logic [3:0] auxIntensity_q;

    // phase 0 level, phase 1 level
    assign auxLevel = (cfg_q[CFG_BLINK_EN] && cfg_q[CFG_PHASE_SEL]) ?
                      cfg_q[CFG_AUX_P1] : cfg_q[CFG_AUX_P0];

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            sharedOe_q <= 1'b0;
        end else if (cfg_q[CFG_IRQ_EN]) begin
            sharedOe_q <= changeFlag_q;
        end else begin
            sharedOe_q <= !auxLevel;
        end
    end

    assign sharedIrqAuxPinOut = 1'b0;
    assign sharedIrqAuxPinOe = sharedOe_q;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            usePhase1_q <= 1'b0;
            auxIntensity_q <= '0;
        end else begin
            usePhase1_q <= cfg_q[CFG_BLINK_EN] && cfg_q[CFG_PHASE_SEL];
            auxIntensity_q <= masterIntensity;
        end
    end

    assign usePhase1 = usePhase1_q;
    assign auxIntensity = auxIntensity_q;
    assign portOutEn = ~dir_q;

    for (genvar i = 0; i < PORTS; i++) begin : gPort
        always_ff @(posedge clk_sys) begin
            if (!resetn) begin
                intensitySel[i*NIBBLE +: NIBBLE] <= '0;
            end else begin
                intensitySel[i*NIBBLE +: NIBBLE] <= cfg_q[CFG_GLOBAL] ?
                    masterIntensity : portIntensity[i*NIBBLE +: NIBBLE];
            end
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    cfg_d6_zero_a: assert property (
        sclFall && state_q == ST_ACK_ADDR && rw_q && ptr_q == REG_CONFIG |=> !tx_q[CFG_RSVD])
        else $error("config reserved bit reads one");
    cfg_flag_read_a: assert property (
        sclFall && state_q == ST_ACK_ADDR && rw_q && ptr_q == REG_CONFIG
        |=> tx_q[CFG_CHANGE] == $past(changeFlag_q))
        else $error("config flag bit differs from change flag");
    irq_pin_drive_a: assert property (
        cfg_q[CFG_IRQ_EN] && $stable(cfg_q) |=> sharedOe_q == $past(changeFlag_q))
        else $error("shared pin not following change flag");
    aux_static_a: assert property (
        !cfg_q[CFG_IRQ_EN] && !cfg_q[CFG_BLINK_EN] |=> sharedOe_q == !$past(cfg_q[CFG_AUX_P0]))
        else $error("shared pin not following phase 0 level");
    aux_phase_one_a: assert property (
        !cfg_q[CFG_IRQ_EN] && cfg_q[CFG_BLINK_EN] && cfg_q[CFG_PHASE_SEL]
        |=> sharedOe_q == !$past(cfg_q[CFG_AUX_P1]))
        else $error("shared pin not following phase 1 level");
    phase_select_a: assert property (
        !cfg_q[CFG_BLINK_EN] |=> !usePhase1)
        else $error("phase 1 used while blink disabled");
    dir_reset_a: assert property (
        $past(!resetn) |-> dir_q == DIR_RESET ##1 (!wrStb)[*2] ##0 dir_q == DIR_RESET)
        else $error("ports not inputs after reset");
    write_commit_a: assert property (
        !$stable(cfg_q) || !$stable(dir_q) |-> $past(wrStb))
        else $error("register changed without a completed byte");
    change_detect_a: assert property (
        initCnt_q == 2'h0 && |((pinS ^ snap_q) & dir_q) |=> changeFlag_q)
        else $error("input change not flagged");
    global_int_a: assert property (
        cfg_q[CFG_GLOBAL] |=> intensitySel[NIBBLE-1:0] == $past(masterIntensity))
        else $error("global intensity not applied");

endmodule : ecx_config_regs

// ### verif/ecx_i2c_master.sv
`timescale 1ns/1ps
module ecx_i2c_master
    import ecx_pkg::*;
#(
    parameter real QTR_NS = 12.0
) (
    input wire logic sdaOe,
    output logic scl,
    output logic sdaIn
);
    logic pull;
    // open drain with pull-up: a released line reads high
    assign sdaIn = ~(pull | sdaOe);
    initial begin
        scl = 1'b1;
        pull = 1'b0;
    end
    // quarters of a 48 ns link period; the link runs free of clk_sys
    task automatic hw(input int n);
        #(QTR_NS * n);
    endtask : hw
    // sda only moves mid-low, so no false start or stop
    task automatic bitx(input logic b, output logic s);
        hw(1);
        pull <= ~b;
        hw(1);
        scl <= 1'b1;
        hw(2);
        s = sdaIn;
        scl <= 1'b0;
    endtask : bitx
    task automatic start();
        hw(1);
        pull <= 1'b0;
        hw(1);
        scl <= 1'b1;
        hw(2);
        pull <= 1'b1;
        hw(2);
        scl <= 1'b0;
    endtask : start
    task automatic stop();
        hw(1);
        pull <= 1'b1;
        hw(1);
        scl <= 1'b1;
        hw(2);
        pull <= 1'b0;
        hw(2);
    endtask : stop
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], s);
        end
        bitx(1'b1, s);
        ack = ~s;
    endtask : wbyte
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
        logic k0;
        logic k1;
        logic k2;
        start();
        wbyte({DEV_ADDR_DEFAULT, 1'b0}, k0);
        wbyte(a, k1);
        wbyte(d, k2);
        stop();
        ok = k0 & k1 & k2;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        logic k;
        start();
        wbyte({DEV_ADDR_DEFAULT, 1'b0}, k);
        wbyte(a, k);
        start();
        wbyte({DEV_ADDR_DEFAULT, 1'b1}, k);
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, d[i]);
        end
        // no acknowledge ends the read
        bitx(1'b1, k);
        stop();
    endtask : rd
endmodule : ecx_i2c_master

// ### verif/test_expander_config_and_direction_regs.sv
`timescale 1ns/1ps
module test_expander_config_and_direction_regs;
    import ecx_pkg::*;
    typedef struct packed {
        logic [7:0] w;
        logic [7:0] r;
        logic ph1;
        logic oe;
    } ecx_row_t;
    localparam logic [63:0] PI = 64'h0123456789ABCDEF;
    localparam logic [3:0] MI = 4'hA;
    logic clk_sys, resetn, scl, sdaIn, sdaOe, snapLow, snapHigh, usePhase1, pinOe;
    logic sdaDrive, pinDrive;
    logic [15:0] portPin, portOutEn;
    logic [63:0] portIntensity, intensitySel;
    logic [3:0] masterIntensity, auxIntensity;
    int failures = 0;
    int n_checks = 0;
    int cyc = 0;
    ecx_row_t rows [9] = '{'{8'h00, 8'h00, 1'b0, 1'b1}, '{8'h10, 8'h10, 1'b0, 1'b0},
        '{8'h02, 8'h02, 1'b0, 1'b1}, '{8'h21, 8'h21, 1'b0, 1'b1},
        '{8'h11, 8'h11, 1'b0, 1'b0}, '{8'h13, 8'h13, 1'b1, 1'b1},
        '{8'h33, 8'h33, 1'b1, 1'b0}, '{8'hC4, 8'h04, 1'b0, 1'b1},
        '{8'h0C, 8'h0C, 1'b0, 1'b0}};
    ecx_config_regs uut (.clk_sys(clk_sys), .resetn(resetn), .scl(scl), .sdaIn(sdaIn),
        .sdaOut(sdaDrive), .sdaOe(sdaOe), .portPin(portPin), .snapLow(snapLow),
        .snapHigh(snapHigh),
        .portIntensity(portIntensity), .masterIntensity(masterIntensity),
        .portOutEn(portOutEn), .usePhase1(usePhase1), .intensitySel(intensitySel),
        .auxIntensity(auxIntensity), .sharedIrqAuxPinOut(pinDrive), .sharedIrqAuxPinOe(pinOe));
    ecx_i2c_master mst (.sdaOe(sdaOe), .scl(scl), .sdaIn(sdaIn));
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // --------
    // checking and closing
    // --------
    task automatic chkReg(input logic [7:0] got, input logic [7:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chkReg
    task automatic chkOut(input logic [63:0] got, input logic [63:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chkOut
    task automatic tally_and_finish();
        $display("checks %0d, failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            $display("wrong value at %0t: timeout", $time);
            tally_and_finish();
        end
    end
    task automatic resetDut();
        resetn <= 1'b0;
        repeat (10) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (8) @(posedge clk_sys);
    endtask : resetDut
    // --------
    // main sequence
    // --------
    initial begin
        logic [7:0] d;
        logic ok;
        logic s;
        resetn = 1'b0;
        snapLow = 1'b0;
        snapHigh = 1'b0;
        portPin = 16'h0000;
        portIntensity = PI;
        masterIntensity = MI;
        resetDut();
        chkOut({48'h0, portOutEn}, 64'h0, "reset dirs");
        chkOut({62'h0, sdaDrive, pinDrive}, 64'h0, "drive levels");
        mst.rd(REG_CONFIG, d);
        chkReg(d, CFG_RESET, "reset cfg");
        mst.rd(REG_DIR_HI, d);
        chkReg(d, 8'hFF, "reset dir hi");
        $display("test reset done");
        foreach (rows[i]) begin
            mst.wr(REG_CONFIG, rows[i].w, ok);
            chkOut({63'h0, ok}, 64'h1, "cfg ack");
            chkOut({63'h0, usePhase1}, {63'h0, rows[i].ph1}, "phase");
            chkOut({63'h0, pinOe}, {63'h0, rows[i].oe}, "pin");
            chkOut(intensitySel, rows[i].w[CFG_GLOBAL] ? {16{MI}} : PI, "int");
            chkOut({60'h0, auxIntensity}, {60'h0, MI}, "aux int");
            mst.rd(REG_CONFIG, d);
            chkReg(d, rows[i].r, "cfg read");
        end
        $display("test rows done");
        mst.wr(REG_DIR_LO, 8'h5A, ok);
        mst.wr(REG_DIR_HI, 8'hA5, ok);
        chkOut({48'h0, portOutEn}, 64'h0000_0000_0000_5AA5, "dir out");
        mst.rd(REG_DIR_LO, d);
        chkReg(d, 8'h5A, "dir lo");
        mst.rd(REG_DIR_HI, d);
        chkReg(d, 8'hA5, "dir hi");
        $display("test direction done");
        @(posedge clk_sys);
        portPin[0] <= 1'b1;
        repeat (10) @(posedge clk_sys);
        chkOut({63'h0, pinOe}, 64'h0, "output port change");
        portPin[1] <= 1'b1;
        repeat (10) @(posedge clk_sys);
        chkOut({63'h0, pinOe}, 64'h1, "irq low");
        mst.rd(REG_CONFIG, d);
        chkReg(d, 8'h8C, "flag set");
        @(posedge clk_sys);
        snapLow <= 1'b1;
        @(posedge clk_sys);
        snapLow <= 1'b0;
        repeat (5) @(posedge clk_sys);
        chkOut({63'h0, pinOe}, 64'h0, "snap clears");
        portPin[8] <= 1'b1;
        repeat (10) @(posedge clk_sys);
        chkOut({63'h0, pinOe}, 64'h1, "high change");
        mst.wr(REG_CONFIG, 8'h0C, ok);
        mst.rd(REG_CONFIG, d);
        chkReg(d, 8'h0C, "cfg write snap");
        $display("test change done");
        mst.start();
        mst.wbyte(8'h42, ok);
        mst.stop();
        chkOut({63'h0, ok}, 64'h0, "foreign addr");
        mst.wr(8'h20, 8'h55, ok);
        mst.rd(8'h20, d);
        chkReg(d, READ_UNMAPPED, "unmapped");
        mst.start();
        mst.wbyte({DEV_ADDR_DEFAULT, 1'b0}, ok);
        mst.wbyte(REG_CONFIG, ok);
        for (int i = 0; i < 4; i++) begin
            mst.bitx(1'b0, s);
        end
        mst.stop();
        mst.rd(REG_CONFIG, d);
        chkReg(d, 8'h0C, "partial byte");
        $display("test refusals done");
        @(posedge clk_sys);
        resetDut();
        chkOut({48'h0, portOutEn}, 64'h0, "rereset dirs");
        chkOut({63'h0, pinOe}, 64'h0, "rereset no irq");
        mst.rd(REG_DIR_LO, d);
        chkReg(d, 8'hFF, "rereset dir lo");
        $display("test second reset done");
        tally_and_finish();
    end
endmodule : test_expander_config_and_direction_regs
